/* File: hw/pdk_panel.v */
// pdk_panel.v: operator panel dial decode, set-frequency stepping and key lock.
// assumes key and dial inputs, except the MODE level, are debounced one-cycle events, synchronous to i_mclk.
// Functional notes
// RQ1: RUN key starts forward when direction setting is 0, reverse when 1.
// RQ2: hold a language code 0..7 for the handheld unit, reset value 0.
// RQ3: panel operation codes 0,1,10,11 select step/pot mode and lock permission.
// RQ4: pot mode applies each dial click at once, running or stopped, no SET.
// RQ5: after a pot-mode dial change, blink set frequency about five seconds.
// RQ6: store a dial-changed set frequency to EEPROM ten seconds after change.
// RQ7: dial increases clamp at the maximum frequency limit, default 120 Hz.
// RQ8: with lock permitted, MODE held two seconds disables dial and keys.
// RQ9: while locked, MODE held two seconds re-enables dial and keys.
// RQ10: locked shows indication, rejection on attempts, monitor after two idle seconds.
// RQ11: while locked, monitor display still updates and STOP still acts.
// RQ12: key release of a panel stop is refused until the lock is released.
// RQ13: step setting 0 changes the set frequency by 0.01 Hz per click.
// RQ14: step settings 0.01, 0.1, 1, 10 change by that many hertz per click.
// RQ15: one dial turn is 24 clicks, each one increment or decrement.
// RQ16: the four settings are writable only while extended display select is 0.
// RQ17: at set frequency 100 or more the step is at least 0.1.
// RQ18: clockwise clicks raise, counter-clockwise lower, never below zero.
`timescale 1ns/1ps
`include "pdk_regs.vh"

module pdk_panel #(
   parameter FW = 16,
   parameter [29:0] BLINK_CYCLES = `PDK_BLINK_S * `PDK_CLK_HZ,
   parameter [29:0] SAVE_CYCLES = `PDK_SAVE_S * `PDK_CLK_HZ,
   parameter [29:0] HOLD_CYCLES = `PDK_HOLD_S * `PDK_CLK_HZ,
   parameter [29:0] IDLE_CYCLES = `PDK_IDLE_S * `PDK_CLK_HZ
) (
   input wire i_mclk, // system clock, 50 MHz
   input wire i_reset, // sync reset, active high
   input wire i_dial_cw, // one clockwise detent click, pulse
   input wire i_dial_ccw, // one counter-clockwise detent click, pulse
   input wire i_key_run, // RUN key press, pulse
   input wire i_key_stop, // STOP key press, pulse
   input wire i_key_set, // SET key press, pulse
   input wire i_key_mode, // MODE key level, high while held
   input wire i_key_other, // any other panel key press, pulse
   input wire i_stop_release, // key request to release a panel stop, pulse
   input wire [7:0] i_extended_display_select, // 0 allows settings writes
   input wire i_cfg_write, // write the four settings below, pulse
   input wire i_run_direction_select, // 0 forward, 1 reverse
   input wire [2:0] i_display_language_select, // language code 0..7
   input wire [1:0] i_panel_dial_lock_select, // code 0,1,10,11 as 2 bits
   input wire [2:0] i_dial_step_size, // 0 def,1 .01,2 .1,3 1,4 10 Hz
   input wire [FW-1:0] i_maximum_frequency_limit, // 0.01 Hz units
   input wire [FW-1:0] i_monitor_value, // live monitor value
   output reg o_run_fwd, // start forward, pulse
   output reg o_run_rev, // start reverse, pulse
   output reg o_stop, // stop request, pulse
   output reg o_panel_stopped, // panel stop in force
   output reg [FW-1:0] o_set_freq, // set frequency, 0.01 Hz units
   output reg o_freq_blink, // blink set frequency display
   output reg o_eeprom_write, // store set frequency, pulse
   output reg [FW-1:0] o_eeprom_data, // value to store
   output reg o_locked, // dial and keys disabled
   output reg [1:0] o_display_mode, // monitor, locked, reject
   output reg [FW-1:0] o_monitor_value, // monitor shown while locked too
   output reg o_run_direction_select, // held direction setting
   output reg [2:0] o_display_language_select, // held language code
   output reg [1:0] o_panel_dial_lock_select, // held panel operation code
   output reg [2:0] o_dial_step_size // held step code
);

   // ***************************************************
   // settings
   // ***************************************************
   reg [1:0] opsel_reg;
   reg [2:0] step_reg;
   wire cfg_ok;

   assign cfg_ok = i_cfg_write && (i_extended_display_select == 8'h00); // [RQ16]

   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_run_direction_select <= `PDK_RST_DIR;
         o_display_language_select <= `PDK_RST_LANG; // [RQ2]
         opsel_reg <= `PDK_RST_OPSEL;
         step_reg <= `PDK_RST_STEP;
      end else if (cfg_ok) begin
         o_run_direction_select <= i_run_direction_select;
         o_display_language_select <= i_display_language_select; // [RQ2]
         opsel_reg <= i_panel_dial_lock_select; // [RQ3]
         // codes above 10 Hz are not defined; keep the old step
         if (i_dial_step_size <= `PDK_STEP_10) begin
            step_reg <= i_dial_step_size;
         end
      end
   end

   always @* begin
      o_panel_dial_lock_select = opsel_reg;
      o_dial_step_size = step_reg;
   end

   // ***************************************************
   // lock and MODE long-press
   // ***************************************************
   wire hold_busy;
   wire hold_done;
   wire idle_busy;
   wire idle_done;
   reg mode_d_reg;
   reg hold_fired_reg;
   wire mode_rise;
   wire lock_allowed;
   wire attempt;

   assign mode_rise = i_key_mode && !mode_d_reg;
   assign lock_allowed = opsel_reg[`PDK_OPSEL_LK_BIT]; // [RQ3]
   // STOP is not an attempt: it still acts while locked
   assign attempt = i_dial_cw || i_dial_ccw || i_key_run || i_key_set || i_key_other ||
      mode_rise;

   pdk_timer #(
      .WIDTH(30),
      .LOAD(HOLD_CYCLES - 30'h1)
   ) u_hold (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(mode_rise),
      .i_cancel(!i_key_mode),
      .o_busy(hold_busy),
      .o_done(hold_done)
   );

   always @(posedge i_mclk) begin
      if (i_reset) begin
         mode_d_reg <= 1'b0;
         hold_fired_reg <= 1'b0;
         o_locked <= 1'b0;
      end else begin
         mode_d_reg <= i_key_mode;
         // one-cycle mark of lock entry, seen by the display once o_locked is up
         hold_fired_reg <= 1'b0;
         if (hold_done && i_key_mode) begin
            if (o_locked) begin
               o_locked <= 1'b0; // [RQ9]
            end else if (lock_allowed) begin
               o_locked <= 1'b1; // [RQ8]
               hold_fired_reg <= 1'b1; // [RQ10]
            end
         end else if (!lock_allowed) begin
            // lock cannot persist once the setting forbids it
            o_locked <= 1'b0;
         end
      end
   end

   // rejection message shows until two seconds without activity
   pdk_timer #(
      .WIDTH(30),
      .LOAD(IDLE_CYCLES - 30'h1)
   ) u_idle (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(o_locked && attempt),
      .i_cancel(!o_locked),
      .o_busy(idle_busy),
      .o_done(idle_done)
   );

   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_display_mode <= `PDK_DISP_MONITOR;
         o_monitor_value <= {FW{1'b0}};
      end else begin
         o_monitor_value <= i_monitor_value; // [RQ11]
         if (!o_locked) begin
            o_display_mode <= `PDK_DISP_MONITOR;
         end else if (attempt) begin
            o_display_mode <= `PDK_DISP_REJECT; // [RQ10]
         end else if (idle_done) begin
            o_display_mode <= `PDK_DISP_MONITOR; // [RQ10]
         end else if (hold_fired_reg) begin
            o_display_mode <= `PDK_DISP_LOCKED; // [RQ10]
         end
      end
   end

   // ***************************************************
   // run, stop and panel stop release
   // ***************************************************
   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_run_fwd <= 1'b0;
         o_run_rev <= 1'b0;
         o_stop <= 1'b0;
         o_panel_stopped <= 1'b0;
      end else begin
         o_run_fwd <= i_key_run && !o_locked && !o_run_direction_select; // [RQ1]
         o_run_rev <= i_key_run && !o_locked && o_run_direction_select; // [RQ1]
         o_stop <= i_key_stop; // [RQ11]
         if (i_key_stop) begin
            o_panel_stopped <= 1'b1; // [RQ11]
         end else if (i_stop_release && !o_locked) begin
            o_panel_stopped <= 1'b0; // [RQ12]
         end
      end
   end

   // ***************************************************
   // dial stepping
   // ***************************************************
   reg [FW-1:0] step_amt;
   reg [FW:0] sum_wide;
   reg [FW-1:0] freq_next;
   // pending value: what the dial edits; equals the set frequency in pot mode
   reg [FW-1:0] pending_reg;
   wire dial_ok;
   wire dial_step;

   // each detent is one event; a cw and ccw in one cycle cancel
   assign dial_ok = !o_locked && (i_dial_cw ^ i_dial_ccw); // [RQ15]
   // in step mode the new value waits for SET
   assign dial_step = dial_ok;

   always @* begin
      case (step_reg)
         `PDK_STEP_DEF: step_amt = `PDK_INC_0P01; // [RQ13]
         `PDK_STEP_0P01: step_amt = `PDK_INC_0P01; // [RQ14]
         `PDK_STEP_0P1: step_amt = `PDK_INC_0P1; // [RQ14]
         `PDK_STEP_1: step_amt = `PDK_INC_1; // [RQ14]
         `PDK_STEP_10: step_amt = `PDK_INC_10; // [RQ14]
         default: step_amt = `PDK_INC_0P01;
      endcase
      if (pending_reg >= `PDK_COARSE_FREQ && step_amt < `PDK_INC_0P1) begin
         step_amt = `PDK_INC_0P1; // [RQ17]
      end
      sum_wide = {1'b0, pending_reg} + {1'b0, step_amt};
      if (i_dial_cw) begin
         if (sum_wide > {1'b0, i_maximum_frequency_limit}) begin
            freq_next = i_maximum_frequency_limit; // [RQ7]
         end else begin
            freq_next = sum_wide[FW-1:0]; // [RQ18]
         end
      end else if (pending_reg > step_amt) begin
         freq_next = pending_reg - step_amt; // [RQ18]
      end else begin
         freq_next = {FW{1'b0}}; // [RQ18]
      end
   end

   wire pot_mode;
   wire apply;
   wire blink_busy;
   wire save_done;

   assign pot_mode = opsel_reg[`PDK_OPSEL_POT_BIT]; // [RQ3]
   assign apply = (pot_mode && dial_step) || (!pot_mode && i_key_set && !o_locked);

   always @(posedge i_mclk) begin
      if (i_reset) begin
         pending_reg <= {FW{1'b0}};
         o_set_freq <= {FW{1'b0}};
      end else begin
         if (dial_step) begin
            pending_reg <= freq_next;
         end
         if (pot_mode && dial_step) begin
            o_set_freq <= freq_next; // [RQ4]
         end else if (apply) begin
            o_set_freq <= pending_reg;
         end
      end
   end

   pdk_timer #(
      .WIDTH(30),
      .LOAD(BLINK_CYCLES - 30'h1)
   ) u_blink (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(pot_mode && dial_step), // [RQ5]
      .i_cancel(1'b0),
      .o_busy(blink_busy),
      .o_done()
   );

   // restarted by each change, so the store follows the last pot-mode click or step-mode SET
   pdk_timer #(
      .WIDTH(30),
      .LOAD(SAVE_CYCLES - 30'h1)
   ) u_save (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(apply), // [RQ6]
      .i_cancel(1'b0),
      .o_busy(),
      .o_done(save_done)
   );

   always @(posedge i_mclk) begin
      if (i_reset) begin
         o_freq_blink <= 1'b0;
         o_eeprom_write <= 1'b0;
         o_eeprom_data <= {FW{1'b0}};
      end else begin
         o_freq_blink <= blink_busy; // [RQ5]
         o_eeprom_write <= save_done; // [RQ6]
         if (save_done) begin
            o_eeprom_data <= o_set_freq; // [RQ6]
         end
      end
   end

endmodule // pdk_panel

/* File: hw/pdk_regs.vh */
// pdk_regs.vh: constants for the operator panel dial and key lock block.
// assumes a single 50 MHz clock; frequencies are held in 0.01 Hz units.
`ifndef PDK_REGS_VH
`define PDK_REGS_VH

// ***************************************************
// clock and times
// ***************************************************
`define PDK_CLK_HZ 50000000
`define PDK_BLINK_S 5
`define PDK_SAVE_S 10
`define PDK_HOLD_S 2
`define PDK_IDLE_S 2

// ***************************************************
// reset values
// ***************************************************
`define PDK_RST_DIR 1'h0
`define PDK_RST_LANG 3'h0
`define PDK_RST_OPSEL 2'h0
`define PDK_RST_STEP 3'h0
`define PDK_RST_FMAX 16'h2ee0

// ***************************************************
// panel operation codes, bit 1 = lock permitted, bit 0 = pot mode
// ***************************************************
`define PDK_OPSEL_STEP 2'h0
`define PDK_OPSEL_POT 2'h1
`define PDK_OPSEL_STEP_LK 2'h2
`define PDK_OPSEL_POT_LK 2'h3
`define PDK_OPSEL_POT_BIT 0
`define PDK_OPSEL_LK_BIT 1

// ***************************************************
// step size codes and sizes in 0.01 Hz
// ***************************************************
`define PDK_STEP_DEF 3'h0
`define PDK_STEP_0P01 3'h1
`define PDK_STEP_0P1 3'h2
`define PDK_STEP_1 3'h3
`define PDK_STEP_10 3'h4
`define PDK_INC_0P01 16'h0001
`define PDK_INC_0P1 16'h000a
`define PDK_INC_1 16'h0064
`define PDK_INC_10 16'h03e8
`define PDK_COARSE_FREQ 16'h2710

// ***************************************************
// display states
// ***************************************************
`define PDK_DISP_MONITOR 2'h0
`define PDK_DISP_LOCKED 2'h1
`define PDK_DISP_REJECT 2'h2

`define PDK_CLICKS_PER_TURN 24

`endif

/* File: hw/pdk_timer.v */
// pdk_timer.v: restartable one-shot down-counter.
// assumes restart and load occur as single-cycle pulses from the same clock.
`timescale 1ns/1ps

module pdk_timer #(
   parameter WIDTH = 30,
   parameter [WIDTH-1:0] LOAD = {WIDTH{1'b1}}
) (
   input wire i_mclk, // system clock
   input wire i_reset, // sync reset, active high
   input wire i_start, // (re)start the count
   input wire i_cancel, // stop without expiry
   output reg o_busy, // counting
   output reg o_done // one-cycle pulse at expiry
);

   reg [WIDTH-1:0] count_reg;

   always @(posedge i_mclk) begin
      if (i_reset) begin
         count_reg <= {WIDTH{1'b0}};
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            count_reg <= LOAD;
            o_busy <= 1'b1;
         end else if (i_cancel) begin
            o_busy <= 1'b0;
         end else if (o_busy) begin
            if (count_reg == {WIDTH{1'b0}}) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end else begin
               count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // pdk_timer

/* File: testbench/pdk_operator.sv */
// pdk_operator.sv: operator at the panel keys and dial.
// assumes one task at a time, called just after a clock edge.
`timescale 1ns/1ps

module pdk_operator (
   input wire i_mclk, // panel clock
   output logic o_cw, // detent up
   output logic o_ccw, // detent down
   output logic o_run, // run key
   output logic o_stop, // stop key
   output logic o_set, // set key
   output logic o_mode, // mode level
   output logic o_other, // other key
   output logic o_rel // stop release
);
   initial {o_cw, o_ccw, o_run, o_stop, o_set, o_mode, o_other, o_rel} = 8'h0;

   // ***********
   // actions
   // ***********
   // one detent per cycle, fastest a hand can turn
   task automatic click(input logic up, input int n);
      o_cw = up;
      o_ccw = !up;
      repeat (n) @(posedge i_mclk);
      #1;
      {o_cw, o_ccw} = 2'h0;
      @(posedge i_mclk);
      #1;
   endtask

   task automatic press(input int k);
      {o_rel, o_other, o_set, o_stop, o_run} = 5'h1 << k;
      @(posedge i_mclk);
      #1;
      {o_rel, o_other, o_set, o_stop, o_run} = 5'h0;
      @(posedge i_mclk);
      #1;
   endtask

   task automatic hold(input int n);
      o_mode = 1'b1;
      repeat (n) @(posedge i_mclk);
      #1;
      o_mode = 1'b0;
      @(posedge i_mclk);
      #1;
   endtask
endmodule // pdk_operator

/* File: testbench/pdk_panel_assertions.sv */
// pdk_panel_assertions.sv: checker for the panel block.
// assumes one clock, sync active-high reset.
`timescale 1ns/1ps
`include "pdk_regs.vh"

module pdk_panel_checker #(
   parameter [29:0] HOLD_CYCLES = 30'h14
) (
   input wire i_mclk, // clock
   input wire i_reset, // reset
   input wire i_dial_cw, // up
   input wire i_dial_ccw, // down
   input wire i_key_run, // run
   input wire i_key_stop, // stop
   input wire i_key_set, // set
   input wire i_key_mode, // mode
   input wire i_key_other, // other
   input wire [7:0] i_extended_display_select, // gate
   input wire i_cfg_write, // write
   input wire i_run_direction_select, // dir
   input wire [2:0] i_display_language_select, // lang
   input wire [15:0] i_maximum_frequency_limit, // limit
   input wire o_run_fwd, // fwd
   input wire o_run_rev, // rev
   input wire o_stop, // stop
   input wire o_panel_stopped, // stopped
   input wire [15:0] o_set_freq, // freq
   input wire o_freq_blink, // blink
   input wire o_locked, // lock
   input wire [1:0] o_display_mode, // display
   input wire o_run_direction_select, // dir
   input wire [2:0] o_display_language_select, // lang
   input wire [1:0] o_panel_dial_lock_select, // op
   input wire [2:0] o_dial_step_size // step
);
   // ***********
   // length of the latest mode press, kept after release
   // ***********
   logic mode_reg;
   logic [31:0] held_reg;
   always @(posedge i_mclk) begin
      if (i_reset) begin
         mode_reg <= 1'b0;
         held_reg <= 32'h0;
      end else begin
         mode_reg <= i_key_mode;
         if (i_key_mode && !mode_reg)
            held_reg <= 32'h1;
         else if (i_key_mode)
            held_reg <= held_reg + 32'h1;
      end
   end

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   sequence s_pot_cw;
      o_panel_dial_lock_select[0] && !o_locked && i_dial_cw && !i_dial_ccw;
   endsequence
   sequence s_pot_ccw;
      o_panel_dial_lock_select[0] && !o_locked && i_dial_ccw && !i_dial_cw;
   endsequence

   // ***********
   // properties
   // ***********
   a_run_dir: assert property (
      i_key_run && !o_locked |=> o_run_fwd != o_run_rev && o_run_rev == $past(o_run_direction_select))
      else $error("run start direction wrong");
   a_stop_pass: assert property (
      i_key_stop |=> o_stop && o_panel_stopped) else $error("stop not acted on");
   a_stop_hold: assert property (
      o_locked && o_panel_stopped && !i_key_stop |=> o_panel_stopped)
      else $error("panel stop released while locked");
   a_cfg_take: assert property (
      i_cfg_write && i_extended_display_select == 8'h0 |=>
      o_display_language_select == $past(i_display_language_select)
      && o_run_direction_select == $past(i_run_direction_select)) else $error("setting not taken");
   a_pot_step: assert property (
      s_pot_cw ##0 (o_dial_step_size == 3'h3
      && {1'b0, o_set_freq} + 17'h64 <= {1'b0, i_maximum_frequency_limit})
      |=> o_set_freq == $past(o_set_freq) + 16'h64) else $error("pot step wrong");
   a_freq_clamp: assert property (
      s_pot_cw |=> o_set_freq <= $past(i_maximum_frequency_limit)) else $error("limit passed");
   a_freq_floor: assert property (
      s_pot_ccw ##0 (o_dial_step_size == 3'h4 && o_set_freq < 16'h3e8) |=> o_set_freq == 16'h0)
      else $error("floor not held");
   a_blink_start: assert property (
      s_pot_cw ##1 $changed(o_set_freq) |=> o_freq_blink) else $error("no blink");
   a_reject_show: assert property (
      o_locked && !i_key_mode && !i_cfg_write
      && (i_dial_cw || i_key_run || i_key_set || i_key_other)
      |=> o_display_mode == `PDK_DISP_REJECT) else $error("no reject display");
   a_lock_hold: assert property (
      $rose(o_locked) |-> held_reg >= HOLD_CYCLES && o_panel_dial_lock_select[1])
      else $error("lock without long press");
endmodule // pdk_panel_checker

/* File: testbench/testbench.sv */
// testbench.sv: self-checking bench of the panel block.
// assumes the operator model and checker compile first.
`timescale 1ns/1ps

module testbench;
   localparam HOLD = 20;
   localparam IDLE = 20;
   localparam SAVE = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sel = 8'h0;
   logic wr = 1'b0;
   logic dir_in = 1'b0;
   logic [2:0] lang_in = 3'h0;
   logic [1:0] op_in = 2'h0;
   logic [2:0] step_in = 3'h0;
   logic [15:0] lim = 16'h2ee0;
   logic [15:0] mon = 16'h0;
   logic [15:0] wr_data = 16'hffff;
   wire cw, ccw, run, stp, key_set, mode, oth, rel;
   wire fwd, rev, ostop, pstop, blink, ewr, lkd, odir;
   wire [15:0] freq, edata, omon;
   wire [1:0] disp, oop;
   wire [2:0] olang, ostep;
   int num_errors = 0;
   int compares = 0;
   int fwd_cnt = 0;
   int rev_cnt = 0;
   int stop_cnt = 0;
   int wr_cnt = 0;

   always #10 clk = ~clk;

   // pulse outputs are tallied here so no single cycle is missed
   always @(posedge clk) begin
      if (fwd === 1'b1) fwd_cnt++;
      if (rev === 1'b1) rev_cnt++;
      if (ostop === 1'b1) stop_cnt++;
      if (ewr === 1'b1) begin
         wr_cnt++;
         wr_data = edata;
      end
   end

   pdk_operator i_op (.i_mclk(clk), .o_cw(cw), .o_ccw(ccw), .o_run(run), .o_stop(stp),
      .o_set(key_set), .o_mode(mode), .o_other(oth), .o_rel(rel));

   pdk_panel #(.BLINK_CYCLES(30'h28), .SAVE_CYCLES(30'h32), .HOLD_CYCLES(30'h14),
      .IDLE_CYCLES(30'h14)) i_dut (.i_mclk(clk), .i_reset(rst), .i_dial_cw(cw),
      .i_dial_ccw(ccw), .i_key_run(run), .i_key_stop(stp), .i_key_set(key_set),
      .i_key_mode(mode), .i_key_other(oth), .i_stop_release(rel),
      .i_extended_display_select(sel), .i_cfg_write(wr), .i_run_direction_select(dir_in),
      .i_display_language_select(lang_in), .i_panel_dial_lock_select(op_in),
      .i_dial_step_size(step_in), .i_maximum_frequency_limit(lim), .i_monitor_value(mon),
      .o_run_fwd(fwd), .o_run_rev(rev), .o_stop(ostop), .o_panel_stopped(pstop),
      .o_set_freq(freq), .o_freq_blink(blink), .o_eeprom_write(ewr), .o_eeprom_data(edata),
      .o_locked(lkd), .o_display_mode(disp), .o_monitor_value(omon),
      .o_run_direction_select(odir), .o_display_language_select(olang),
      .o_panel_dial_lock_select(oop), .o_dial_step_size(ostep));

   // ***********
   // helpers
   // ***********
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cfg(input logic [7:0] s, input logic d, input logic [2:0] l,
         input logic [1:0] o, input logic [2:0] st);
      {sel, dir_in, lang_in, op_in, step_in, wr} = {s, d, l, o, st, 1'b1};
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask

   task automatic print_verdict;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ***********
   // scenarios
   // ***********
   task automatic t_settings;
      chk({freq, odir, olang, oop, ostep, lkd, disp}, 32'h0);
      cfg(8'h05, 1'b1, 3'h7, 2'h1, 3'h2);
      chk({odir, olang, oop, ostep}, 32'h0);
      for (int k = 0; k < 8; k++) begin
         cfg(8'h0, 1'b0, k[2:0], 2'h0, 3'h3);
         chk(olang, k);
      end
   endtask

   task automatic t_run_step;
      i_op.press(0);
      chk(fwd_cnt, 1);
      cfg(8'h0, 1'b1, 3'h0, 2'h0, 3'h3);
      i_op.press(0);
      chk({fwd_cnt[15:0], rev_cnt[15:0]}, 32'h10001);
      i_op.click(1'b1, 1);
      tick(2);
      chk(freq, 16'h0);
      i_op.press(2);
      tick(2);
      chk(freq, 16'h64);
   endtask

   task automatic t_pot;
      logic [15:0] inc [5] = '{16'h1, 16'h1, 16'ha, 16'h64, 16'h3e8};
      logic [15:0] f;
      int w;
      int n;
      f = 16'h64;
      for (int k = 0; k < 5; k++) begin
         cfg(8'h0, 1'b0, 3'h0, 2'h1, k[2:0]);
         i_op.click(1'b1, 1);
         f = f + inc[k];
         chk(freq, f);
      end
      cfg(8'h0, 1'b0, 3'h0, 2'h1, 3'h4);
      i_op.click(1'b1, 8);
      cfg(8'h0, 1'b0, 3'h0, 2'h1, 3'h3);
      i_op.click(1'b1, 8);
      cfg(8'h0, 1'b0, 3'h0, 2'h1, 3'h1);
      i_op.click(1'b1, 1);
      chk(freq, 16'h2726);
      cfg(8'h0, 1'b0, 3'h0, 2'h1, 3'h4);
      i_op.click(1'b1, 2);
      tick(1);
      chk({blink, freq}, 17'h12ee0);
      cfg(8'h0, 1'b0, 3'h0, 2'h1, 3'h3);
      i_op.click(1'b0, 24);
      chk(freq, 16'h2580);
      cfg(8'h0, 1'b0, 3'h0, 2'h1, 3'h4);
      i_op.click(1'b0, 10);
      w = wr_cnt;
      n = 0;
      while (wr_cnt == w && n < SAVE + 20) begin
         tick(1);
         n++;
      end
      chk({freq, wr_data}, 32'h0);
      chk({n > SAVE - 6 && n < SAVE + 6, blink}, 2'h2);
      lim = 16'h03e8;
      i_op.click(1'b1, 2);
      chk(freq, 16'h03e8);
      i_op.click(1'b0, 1);
      lim = 16'h2ee0;
      chk(freq, 16'h0);
   endtask

   task automatic t_lock;
      int r;
      cfg(8'h0, 1'b0, 3'h0, 2'h3, 3'h4);
      i_op.hold(HOLD - 6);
      tick(3);
      chk(lkd, 1'b0);
      i_op.hold(HOLD + 6);
      chk({lkd, disp}, 3'h5);
      mon = 16'hbeef;
      tick(2);
      chk(omon, 16'hbeef);
      r = fwd_cnt + rev_cnt;
      i_op.press(0);
      chk({fwd_cnt + rev_cnt == r, disp}, 3'h6);
      i_op.click(1'b1, 1);
      chk(freq, 16'h0);
      tick(IDLE + 4);
      chk(disp, 2'h0);
      i_op.press(3);
      chk(disp, 2'h2);
      i_op.press(1);
      chk({stop_cnt[15:0], 15'h0, pstop}, 32'h10001);
      i_op.press(4);
      chk(pstop, 1'b1);
      i_op.hold(HOLD + 6);
      chk(lkd, 1'b0);
      i_op.press(4);
      chk(pstop, 1'b0);
      cfg(8'h0, 1'b0, 3'h0, 2'h0, 3'h0);
      i_op.hold(HOLD + 6);
      chk(lkd, 1'b0);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      t_settings();
      t_run_step();
      t_pot();
      t_lock();
      print_verdict();
   end

   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
endmodule // testbench

bind pdk_panel pdk_panel_checker #(.HOLD_CYCLES(HOLD_CYCLES)) i_chk (.i_mclk(i_mclk),
   .i_reset(i_reset), .i_dial_cw(i_dial_cw), .i_dial_ccw(i_dial_ccw), .i_key_run(i_key_run),
   .i_key_stop(i_key_stop), .i_key_set(i_key_set), .i_key_mode(i_key_mode),
   .i_key_other(i_key_other), .i_extended_display_select(i_extended_display_select),
   .i_cfg_write(i_cfg_write), .i_run_direction_select(i_run_direction_select),
   .i_display_language_select(i_display_language_select),
   .i_maximum_frequency_limit(i_maximum_frequency_limit), .o_run_fwd(o_run_fwd),
   .o_run_rev(o_run_rev), .o_stop(o_stop), .o_panel_stopped(o_panel_stopped),
   .o_set_freq(o_set_freq), .o_freq_blink(o_freq_blink), .o_locked(o_locked),
   .o_display_mode(o_display_mode), .o_run_direction_select(o_run_direction_select),
   .o_display_language_select(o_display_language_select),
   .o_panel_dial_lock_select(o_panel_dial_lock_select), .o_dial_step_size(o_dial_step_size));
